// File: hw/umc_top.sv
`include "umc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module umc_top
    import umc_pkg::*;
#(
    parameter bit REDUCED  = 1'b0,  // Reduced-feature instance.
    parameter bit NO_IRDA  = 1'b0   // Instance without infrared.
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        cts_n_pin,
    input  wire logic        rx_can_accept,
    input  wire logic        tx_empty,
    input  wire logic        rx_full,
    input  wire logic        parity_err,
    input  wire logic        frame_done,
    input  wire logic        baud_tick,
    input  wire logic        framing_error_flag,
    input  wire logic        overrun_error_flag,
    input  wire logic        noise_error_flag,
    output var  umc_mode_s   mode,
    output var  logic        unit_global_enable,
    output var  logic        tx_allowed,
    output var  logic        rts_n_pin,
    output var  logic        tx_dma_req,
    output var  logic        rx_dma_req,
    output var  logic        nack_send,
    output var  logic        error_irq,
    output var  logic        transmission_complete_flag,
    output var  logic        ir_lp_tick,
    output var  logic        card_clock
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and their write masks.

    umc_mode_s   mode_ff;           // Mode control word.
    umc_gp_s     gp_ff;             // Guard time and prescaler.
    logic        uen_ff;            // Unit global enable.
    logic        tc_ff;             // Transmission complete flag.
    logic [31:0] rdata_ff;          // Read data held for access.
    logic        ready_ff;          // Access phase may complete.
    logic        err_ff;            // Unmapped address answer.
    logic [15:0] mode_wm;           // Writable mode bits now.
    logic [15:0] gp_wm;             // Writable guard bits now.
    logic        wr_go;             // Write completes this edge.
    logic        setup;             // Setup phase of a transfer.

    assign setup = psel && !penable;
    assign wr_go = psel && penable && ready_ff && pwrite;

    // Writable masks shrink while enabled and on small instances.
    always_comb begin
        mode_wm = `UMC_MODE_WMASK;
        if (uen_ff) begin
            mode_wm = mode_wm & ~`UMC_MODE_LOCK;
        end
        if (REDUCED) begin
            mode_wm = mode_wm & ~`UMC_MODE_RED;
        end
        if (NO_IRDA) begin
            mode_wm = mode_wm & ~`UMC_MODE_NOIR;
        end
        gp_wm = `UMC_GP_ALL;
        if (uen_ff) begin
            gp_wm = 16'h0000;
        end
        if (REDUCED) begin
            gp_wm = gp_wm & ~`UMC_GP_GT_MASK;
        end
    end

    // Mode word; writes touch only the writable bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= umc_mode_s'(`UMC_RST_MODE);
        end else if (wr_go && paddr == `UMC_OFS_MODE) begin
            mode_ff <= umc_mode_s'((16'(mode_ff) & ~mode_wm)
                                 | (pwdata[15:0] & mode_wm));
        end
    end

    // Guard register; upper half is not stored at all.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gp_ff <= umc_gp_s'(`UMC_RST_GP);
        end else if (wr_go && paddr == `UMC_OFS_GP) begin
            gp_ff <= umc_gp_s'((16'(gp_ff) & ~gp_wm)
                             | (pwdata[15:0] & gp_wm));
        end
    end

    // Unit enable is always writable; it sets the interlock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uen_ff <= 1'b0;
        end else if (wr_go && paddr == `UMC_OFS_UNIT) begin
            uen_ff <= pwdata[`UMC_UNIT_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: read data is fetched in setup, so one access cycle.

    // Read data and error are latched at setup to keep outputs registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= `UMC_RST_WORD;
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
        end else if (setup) begin
            ready_ff <= 1'b1;
            err_ff   <= 1'b0;
            rdata_ff <= `UMC_RST_WORD;
            unique case (paddr)
                `UMC_OFS_MODE: begin
                    rdata_ff[15:0] <= 16'(mode_ff);
                end
                `UMC_OFS_GP: begin
                    rdata_ff[15:0] <= 16'(gp_ff);
                end
                `UMC_OFS_UNIT: begin
                    rdata_ff[`UMC_UNIT_EN] <= uen_ff;
                    rdata_ff[`UMC_UNIT_TC] <= tc_ff;
                    rdata_ff[`UMC_UNIT_FE] <= framing_error_flag;
                    rdata_ff[`UMC_UNIT_OE] <= overrun_error_flag;
                    rdata_ff[`UMC_UNIT_NE] <= noise_error_flag;
                end
                default: begin
                    err_ff <= 1'b1;     // Unmapped: error, data zero.
                end
            endcase
        end else begin
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
        end
    end

    assign prdata  = rdata_ff;
    assign pready  = ready_ff;
    assign pslverr = err_ff;
    assign mode    = mode_ff;
    assign unit_global_enable = uen_ff;

    ////////////////////////////////////////////////////////////////////////
    // Flow control. The cts pin is asynchronous, so it is synchronised.

    logic cts_meta_ff;              // First synchroniser stage only.
    logic cts_sync_ff;              // Safe copy of cts_n_pin.
    logic tx_ok_ff;                 // Transmit allowed.
    logic rts_ff;                   // Registered rts line.

    // Two-stage synchroniser for the clear-to-send pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cts_meta_ff <= 1'b1;
            cts_sync_ff <= 1'b1;
        end else begin
            cts_meta_ff <= cts_n_pin;
            cts_sync_ff <= cts_meta_ff;
        end
    end

    // Transmission waits for a low cts only when gating is on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ok_ff <= 1'b1;
        end else begin
            tx_ok_ff <= !mode_ff.cts_flow || !cts_sync_ff;
        end
    end

    // With rts_flow on, rts goes high when the receiver cannot accept; low otherwise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_ff <= 1'b0;
        end else begin
            rts_ff <= mode_ff.rts_flow && !rx_can_accept;
        end
    end

    assign tx_allowed = tx_ok_ff;
    assign rts_n_pin  = rts_ff;

    ////////////////////////////////////////////////////////////////////////
    // DMA requests, smartcard nack and error interrupt.

    logic txr_ff;                   // Transmit DMA request.
    logic rxr_ff;                   // Receive DMA request.
    logic nack_ff;                  // Nack pulse to the frame engine.
    logic irq_ff;                   // Error interrupt level.

    // Requests follow the data state only while their DMA enable bit is set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txr_ff <= 1'b0;
            rxr_ff <= 1'b0;
        end else begin
            txr_ff <= mode_ff.tx_dma && tx_empty;
            rxr_ff <= mode_ff.rx_dma && rx_full;
        end
    end

    // Nack is asked for only in smartcard mode with nack on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nack_ff <= 1'b0;
        end else begin
            nack_ff <= mode_ff.smartcard && mode_ff.parity_nack
                    && parity_err;
        end
    end

    // Error interrupt is a level while any error flag stands and both err_int and rx_dma are set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= mode_ff.rx_dma && mode_ff.err_int
                   && (framing_error_flag || overrun_error_flag
                       || noise_error_flag);
        end
    end

    assign tx_dma_req = txr_ff;
    assign rx_dma_req = rxr_ff;
    assign nack_send  = nack_ff;
    assign error_irq  = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Guard time: in smartcard mode the complete flag waits baud ticks.

    umc_gt_e    gt_state_ff;        // Guard sequencer state.
    logic [7:0] gt_cnt_ff;          // Baud ticks still to wait.
    logic       tc_set;             // Flag is set this edge.
    logic       tc_clr;             // Software clears the flag.

    // Sequencer: a frame end starts the guard wait when it is nonzero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gt_state_ff <= UMC_GT_IDLE;
            gt_cnt_ff   <= `UMC_ZERO8;
        end else begin
            unique case (gt_state_ff)
                UMC_GT_IDLE: begin
                    if (frame_done && mode_ff.smartcard
                        && gp_ff.guard_time != `UMC_ZERO8) begin
                        gt_state_ff <= UMC_GT_WAIT;
                        gt_cnt_ff   <= gp_ff.guard_time;
                    end
                end
                UMC_GT_WAIT: begin
                    if (baud_tick) begin
                        gt_cnt_ff <= gt_cnt_ff - `UMC_ONE8;
                        if (gt_cnt_ff == `UMC_ONE8) begin
                            gt_state_ff <= UMC_GT_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Flag is set by the last guard tick or at once without guard.
    assign tc_set = (gt_state_ff == UMC_GT_WAIT && baud_tick
                     && gt_cnt_ff == `UMC_ONE8)
                 || (gt_state_ff == UMC_GT_IDLE && frame_done
                     && !(mode_ff.smartcard
                          && gp_ff.guard_time != `UMC_ZERO8));
    assign tc_clr = wr_go && paddr == `UMC_OFS_UNIT
                 && pwdata[`UMC_UNIT_TC];

    // Complete flag: write one clears it; a set in the same edge wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_ff <= 1'b0;
        end else if (tc_set) begin
            tc_ff <= 1'b1;
        end else if (tc_clr) begin
            tc_ff <= 1'b0;
        end
    end

    assign transmission_complete_flag = tc_ff;

    ////////////////////////////////////////////////////////////////////////
    // Clock dividers. A prescaler of zero is reserved and stops them.

    logic [7:0] lp_cnt_ff;          // Low-power divider count.
    logic       lp_tick_ff;         // Low-power pulse, one cycle.
    logic [4:0] sc_cnt_ff;          // Card clock half-period count.
    logic       sc_clk_ff;          // Card clock level.
    logic       lp_run;             // Low-power divider runs.
    logic       sc_run;             // Card clock runs.

    assign lp_run = mode_ff.infrared && mode_ff.ir_low_power
                 && gp_ff.prescaler != `UMC_ZERO8;
    assign sc_run = mode_ff.smartcard
                 && gp_ff.prescaler[4:0] != `UMC_ZERO5;

    // One pulse every prescaler cycles of the peripheral clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_cnt_ff  <= `UMC_ZERO8;
            lp_tick_ff <= 1'b0;
        end else if (!lp_run) begin
            lp_cnt_ff  <= `UMC_ZERO8;
            lp_tick_ff <= 1'b0;
        end else if (lp_cnt_ff >= gp_ff.prescaler - `UMC_ONE8) begin
            lp_cnt_ff  <= `UMC_ZERO8;
            lp_tick_ff <= 1'b1;
        end else begin
            lp_cnt_ff  <= lp_cnt_ff + `UMC_ONE8;
            lp_tick_ff <= 1'b0;
        end
    end

    // Card clock toggles every prescaler[4:0] cycles: period twice that.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc_cnt_ff <= `UMC_ZERO5;
            sc_clk_ff <= 1'b0;
        end else if (!sc_run) begin
            sc_cnt_ff <= `UMC_ZERO5;
            sc_clk_ff <= 1'b0;
        end else if (sc_cnt_ff >= gp_ff.prescaler[4:0] - `UMC_ONE5) begin
            sc_cnt_ff <= `UMC_ZERO5;
            sc_clk_ff <= !sc_clk_ff;
        end else begin
            sc_cnt_ff <= sc_cnt_ff + `UMC_ONE5;
        end
    end

    assign ir_lp_tick = lp_tick_ff;
    assign card_clock = sc_clk_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_frame_no_guard;
        frame_done && gt_state_ff == UMC_GT_IDLE
        && (!mode_ff.smartcard || gp_ff.guard_time == `UMC_ZERO8);
    endsequence

    sequence s_guard_start;
        frame_done && gt_state_ff == UMC_GT_IDLE && mode_ff.smartcard
        && gp_ff.guard_time > `UMC_ONE8;
    endsequence

    a_mode_lock: assert property (
        uen_ff && wr_go |=> (16'(mode_ff) & `UMC_MODE_LOCK)
                        == $past(16'(mode_ff) & `UMC_MODE_LOCK))
        else $error("Locked mode bits changed while enabled.");

    a_gp_lock: assert property (
        uen_ff |=> $stable(gp_ff))
        else $error("Guard register changed while enabled.");

    a_cts_gate: assert property (
        mode_ff.cts_flow && cts_sync_ff ##1 mode_ff.cts_flow |-> !tx_allowed)
        else $error("Transmit allowed with cts high.");

    a_dma_off: assert property (
        !$past(mode_ff.tx_dma) |-> !tx_dma_req)
        else $error("Transmit DMA request while disabled.");

    a_rxdma_off: assert property (
        !$past(mode_ff.rx_dma) |-> !rx_dma_req && !error_irq)
        else $error("Receive request or error irq without DMA.");

    a_irq_raise: assert property (
        mode_ff.rx_dma && mode_ff.err_int && overrun_error_flag
        |=> error_irq)
        else $error("Error interrupt missing.");

    a_nack_mode: assert property (
        nack_send |-> $past(mode_ff.smartcard && mode_ff.parity_nack))
        else $error("Nack outside smartcard nack mode.");

    a_tc_now: assert property (
        s_frame_no_guard |=> transmission_complete_flag)
        else $error("Complete flag late without guard.");

    a_tc_guard: assert property (
        s_guard_start |-> !tc_set ##1 !tc_set)
        else $error("Complete flag set inside guard time.");

    a_gp_reset: assert property (
        $rose(presetn) |-> gp_ff == umc_gp_s'(`UMC_RST_GP))
        else $error("Guard register not zero after reset.");

endmodule

`default_nettype wire

// File: hw/umc_params.svh
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH

// Register byte offsets on the APB port.
`define UMC_OFS_MODE     8'h14
`define UMC_OFS_GP       8'h18
`define UMC_OFS_UNIT     8'h1c

// Reset value shared by every register.
`define UMC_RST_MODE     16'h0000
`define UMC_RST_GP       16'h0000
`define UMC_RST_WORD     32'h0000_0000

// Implemented bits of the mode control word.
`define UMC_MODE_WMASK   16'h03ff
// Mode bits frozen while the unit is enabled.
`define UMC_MODE_LOCK    16'h033e
// Mode bits that reduced instances leave out.
`define UMC_MODE_RED     16'h0330
// Mode bit absent where infrared is not built.
`define UMC_MODE_NOIR    16'h0002

// Guard time field, absent on reduced instances.
`define UMC_GP_GT_MASK   16'hff00
`define UMC_GP_ALL       16'hffff

// Unit register bit positions.
`define UMC_UNIT_EN      0
`define UMC_UNIT_TC      8
`define UMC_UNIT_FE      9
`define UMC_UNIT_OE      10
`define UMC_UNIT_NE      11

// Small constants of the dividers.
`define UMC_ZERO8        8'h00
`define UMC_ONE8         8'h01
`define UMC_ZERO5        5'h00
`define UMC_ONE5         5'h01

`endif

// File: hw/umc_pkg.sv
package umc_pkg;

    // Mode control word, bit 0 at the bottom.
    typedef struct packed {
        logic [5:0] rsvd;           // Bits 15:10 read as zero.
        logic       cts_flow;       // Clear-to-send flow gating.
        logic       rts_flow;       // Request-to-send flow control.
        logic       tx_dma;         // Transmit DMA request enable.
        logic       rx_dma;         // Receive DMA request enable.
        logic       smartcard;      // Smartcard operation.
        logic       parity_nack;    // Nack on parity error.
        logic       half_duplex;    // Single-line operation.
        logic       ir_low_power;   // Infrared low-power pulses.
        logic       infrared;       // Infrared coding on.
        logic       err_int;        // Error interrupt enable.
    } umc_mode_s;

    // Guard time and prescaler, low half of the word.
    typedef struct packed {
        logic [7:0] guard_time;     // Baud cycles of guard time.
        logic [7:0] prescaler;      // Clock prescaler value.
    } umc_gp_s;

    // Guard sequencer states, Gray along the path.
    typedef enum logic {
        UMC_GT_IDLE = 1'b0,
        UMC_GT_WAIT = 1'b1
    } umc_gt_e;

endpackage

// File: sim/umc_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Serial peer model: line status, frame strobes and a free-running baud enable.
module umc_peer #(
    parameter int BAUD_DIV = 4  // Pclk cycles per baud tick.
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    output var  logic       cts_n_pin,
    output var  logic       rx_can_accept,
    output var  logic       tx_empty,
    output var  logic       rx_full,
    output var  logic       parity_err,
    output var  logic       frame_done,
    output var  logic       baud_tick,
    output var  logic [2:0] err_flags
);
    int unsigned div_cnt;  // Baud divider count.

    // Quiet line at start: peer clear to receive, nothing pending.
    initial begin
        cts_n_pin = 1'b0;
        rx_can_accept = 1'b1;
        tx_empty = 1'b0;
        rx_full = 1'b0;
        parity_err = 1'b0;
        frame_done = 1'b0;
        err_flags = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The baud enable runs free, so a guard count always sees ticks.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 0;
            baud_tick <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == BAUD_DIV - 1) ? 0 : div_cnt + 1;
            baud_tick <= (div_cnt == BAUD_DIV - 1);
        end
    end

    // Levels change just after an edge and stand until the next call.
    task automatic set_lines(input logic cts_n, input logic room, input logic txe,
                             input logic rxf, input logic [2:0] errs);
        @(posedge pclk);
        cts_n_pin <= cts_n;
        rx_can_accept <= room;
        tx_empty <= txe;
        rx_full <= rxf;
        err_flags <= errs;
    endtask

    // One-cycle strobe: a parity error, or else the end of a sent frame.
    task automatic pulse(input logic parity);
        @(posedge pclk);
        if (parity) begin
            parity_err <= 1'b1;
        end else begin
            frame_done <= 1'b1;
        end
        @(posedge pclk);
        parity_err <= 1'b0;
        frame_done <= 1'b0;
    endtask
endmodule

`default_nettype wire

// File: sim/tb.sv
`include "umc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb
    import umc_pkg::*;
;
    // One table row: a bus transfer and what it should give back.
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } umc_row_s;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er_v;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        cts_n_pin, rx_can_accept, tx_empty, rx_full, parity_err, frame_done;
    logic        baud_tick, tx_allowed, rts_n_pin, tx_dma_req, rx_dma_req, nack_send;
    logic        error_irq, tc_flag, ir_lp_tick, card_clock, unit_en;
    logic [2:0]  err_flags;
    umc_mode_s   mode;
    int          miscompares, tests_run, hits;
    umc_row_s    rows [8];

    umc_top umc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cts_n_pin(cts_n_pin), .rx_can_accept(rx_can_accept),
        .tx_empty(tx_empty), .rx_full(rx_full), .parity_err(parity_err),
        .frame_done(frame_done), .baud_tick(baud_tick), .framing_error_flag(err_flags[0]),
        .overrun_error_flag(err_flags[1]), .noise_error_flag(err_flags[2]), .mode(mode),
        .unit_global_enable(unit_en), .tx_allowed(tx_allowed), .rts_n_pin(rts_n_pin),
        .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .nack_send(nack_send),
        .error_irq(error_irq), .transmission_complete_flag(tc_flag),
        .ir_lp_tick(ir_lp_tick), .card_clock(card_clock));

    umc_peer umc_peer_i (.pclk(pclk), .presetn(presetn), .cts_n_pin(cts_n_pin),
        .rx_can_accept(rx_can_accept), .tx_empty(tx_empty), .rx_full(rx_full),
        .parity_err(parity_err), .frame_done(frame_done), .baud_tick(baud_tick),
        .err_flags(err_flags));

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Full-word transfer waits for pready, since the slave sets the pace.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd_v, x, "register read");
    endtask

    // Samples after the edge so registered outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Counts cycles that a divider output is high.
    task automatic count(input logic card, input int n);
        hits = 0;
        repeat (n) begin
            @(posedge pclk);
            if ((card ? card_clock : ir_lp_tick) === 1'b1) hits++;
        end
    endtask

    task automatic end_sim();
        $display("counts: %0d compared, %0d wrong", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{1'b0, `UMC_OFS_GP, 32'h0, 32'h0, 1'b0},
                 '{1'b0, `UMC_OFS_MODE, 32'h0, 32'h0, 1'b0},
                 '{1'b1, `UMC_OFS_GP, 32'hffff_ffff, 32'h0, 1'b0},
                 '{1'b0, `UMC_OFS_GP, 32'h0, 32'h0000_ffff, 1'b0},
                 '{1'b1, `UMC_OFS_MODE, 32'hffff_ffff, 32'h0, 1'b0},
                 '{1'b0, `UMC_OFS_MODE, 32'h0, 32'h0000_03ff, 1'b0},
                 '{1'b1, 8'h20, 32'h5, 32'h0, 1'b1},
                 '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}};
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        miscompares = 0;
        tests_run = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd_v, rows[i].x, "table read");
            chk(32'(er_v), 32'(rows[i].e), "table error");
        end
        $display("test table done");
        // Locked fields keep their value while the unit runs; DMA and irq bits do not.
        apb(1'b1, `UMC_OFS_UNIT, 32'h1);
        apb(1'b1, `UMC_OFS_MODE, 32'h0);
        apb(1'b1, `UMC_OFS_GP, 32'h0);
        rd(`UMC_OFS_MODE, 32'h33e);
        rd(`UMC_OFS_GP, 32'hffff);
        apb(1'b1, `UMC_OFS_UNIT, 32'h0);
        $display("test lock done");
        umc_peer_i.set_lines(1'b0, 1'b1, 1'b1, 1'b1, 3'h7);
        tick(2);
        chk(32'({tx_dma_req, rx_dma_req, error_irq}), 32'h0, "dma off");
        apb(1'b1, `UMC_OFS_MODE, 32'hc1);
        tick(1);
        chk(32'({tx_dma_req, rx_dma_req, error_irq}), 32'h7, "dma on");
        apb(1'b1, `UMC_OFS_MODE, 32'h81);
        tick(1);
        chk(32'({tx_dma_req, rx_dma_req, error_irq}), 32'h4, "no rx dma");
        umc_peer_i.set_lines(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
        $display("test dma done");
        apb(1'b1, `UMC_OFS_MODE, 32'h38);
        chk(32'({mode.smartcard, mode.parity_nack, mode.half_duplex}), 32'h7, "mode");
        umc_peer_i.pulse(1'b1);
        #1;
        chk(32'(nack_send), 32'h1, "nack sent");
        apb(1'b1, `UMC_OFS_MODE, 32'h28);
        umc_peer_i.pulse(1'b1);
        #1;
        chk(32'(nack_send), 32'h0, "nack off");
        $display("test nack done");
        apb(1'b1, `UMC_OFS_GP, 32'h0203);
        umc_peer_i.pulse(1'b0);
        hits = 0;
        repeat (40) begin
            @(posedge pclk);
            if (tc_flag === 1'b1) break;
            if (baud_tick === 1'b1) hits++;
        end
        chk(32'(hits), 32'h2, "guard ticks");
        rd(`UMC_OFS_UNIT, 32'h100);
        apb(1'b1, `UMC_OFS_UNIT, 32'h100);
        chk(32'(tc_flag), 32'h0, "flag cleared");
        $display("test guard done");
        apb(1'b1, `UMC_OFS_MODE, 32'h6);
        apb(1'b1, `UMC_OFS_GP, 32'h3);
        chk(32'({mode.ir_low_power, mode.infrared}), 32'h3, "ir mode");
        umc_peer_i.pulse(1'b0);
        #1;
        chk(32'(tc_flag), 32'h1, "flag without guard");
        count(1'b0, 30);
        chk(32'(hits), 32'ha, "low power ticks");
        apb(1'b1, `UMC_OFS_MODE, 32'h2);
        apb(1'b1, `UMC_OFS_GP, 32'h1);
        count(1'b0, 10);
        chk(32'(hits), 32'h0, "no ticks in normal ir");
        apb(1'b1, `UMC_OFS_MODE, 32'h6);
        tick(1);
        count(1'b0, 10);
        chk(32'(hits), 32'ha, "divide by one");
        apb(1'b1, `UMC_OFS_MODE, 32'h20);
        apb(1'b1, `UMC_OFS_GP, 32'he2);
        count(1'b1, 40);
        chk(32'(hits), 32'h14, "card clock high");
        $display("test divider done");
        apb(1'b1, `UMC_OFS_MODE, 32'h300);
        chk(32'({tx_allowed, rts_n_pin}), 32'h2, "flow idle");
        umc_peer_i.set_lines(1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
        tick(4);
        chk(32'({tx_allowed, rts_n_pin}), 32'h1, "flow held");
        apb(1'b1, `UMC_OFS_MODE, 32'h0);
        tick(4);
        chk(32'({tx_allowed, rts_n_pin}), 32'h2, "flow off");
        $display("test flow done");
        @(posedge pclk);
        presetn <= 1'b0;
        tick(2);
        chk(32'({tx_allowed, unit_en}), 32'h2, "in reset");
        presetn <= 1'b1;
        rd(`UMC_OFS_GP, 32'h0);
        $display("test reset done");
        end_sim();
    end
endmodule

`default_nettype wire
